// file: logic/twcr_pkg.sv
// constants and types shared by the transceiver and wake configuration register bank
package twcr_pkg;

  // -------------------------------------------------------------------------
  // serial frame layout
  // -------------------------------------------------------------------------
  localparam int unsigned TWCR_FRAME_BITS = 16;
  localparam int unsigned TWCR_ADDR_BITS  = 7;
  localparam int unsigned TWCR_DATA_BITS  = 8;
  localparam logic [4:0]  TWCR_CNT_ADDR   = 5'h08;
  localparam logic [4:0]  TWCR_CNT_FRAME  = 5'h10;

  // -------------------------------------------------------------------------
  // register addresses, reset values and implemented-bit masks
  // -------------------------------------------------------------------------
  localparam logic [6:0] TWCR_ADDR_PRIMARY   = 7'h04;
  localparam logic [6:0] TWCR_ADDR_SECONDARY = 7'h05;
  localparam logic [6:0] TWCR_ADDR_INT_WAKE  = 7'h06;
  localparam logic [6:0] TWCR_ADDR_EXT_WAKE  = 7'h07;

  localparam logic [7:0] TWCR_PRIMARY_RST   = 8'h20;
  localparam logic [7:0] TWCR_SECONDARY_RST = 8'h00;
  localparam logic [7:0] TWCR_INT_WAKE_RST  = 8'h00;
  localparam logic [7:0] TWCR_EXT_WAKE_RST  = 8'h07;

  localparam logic [7:0] TWCR_PRIMARY_MASK   = 8'hfb;
  localparam logic [7:0] TWCR_SECONDARY_MASK = 8'h23;
  localparam logic [7:0] TWCR_INT_WAKE_MASK  = 8'hc4;
  localparam logic [7:0] TWCR_EXT_WAKE_MASK  = 8'ha7;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int unsigned TWCR_PRI_FLASH_BIT   = 7;
  localparam int unsigned TWCR_PRI_LOWSLP_BIT  = 6;
  localparam int unsigned TWCR_PRI_TXDTO_BIT   = 5;
  localparam int unsigned TWCR_PRI_FIRST_LIN_MODE_LSB    = 3;
  localparam int unsigned TWCR_PRI_CAN_LSB     = 0;
  localparam int unsigned TWCR_SEC_PEAK_BIT    = 5;
  localparam int unsigned TWCR_SEC_SECOND_LIN_MODE_LSB    = 0;
  localparam int unsigned TWCR_INT_TMR2_BIT    = 7;
  localparam int unsigned TWCR_INT_TMR1_BIT    = 6;
  localparam int unsigned TWCR_INT_WDSTOP_BIT  = 2;
  localparam int unsigned TWCR_EXT_GLOBAL_BIT  = 7;
  localparam int unsigned TWCR_EXT_MEAS_BIT    = 5;

  // transceiver mode codes
  localparam logic [1:0] TWCR_TRX_OFF    = 2'h0;
  localparam logic [1:0] TWCR_TRX_WAKE   = 2'h1;
  localparam logic [1:0] TWCR_TRX_RXONLY = 2'h2;
  localparam logic [1:0] TWCR_TRX_NORMAL = 2'h3;

  // value forced into the external wake enables on fail-safe entry
  localparam logic [2:0] TWCR_FAIL_WAKE_EN = 3'h7;

  // operating mode of the chip, driven by the main state machine
  typedef enum logic [2:0] {
    TWCR_SBC_INIT,
    TWCR_SBC_NORMAL,
    TWCR_SBC_STOP,
    TWCR_SBC_SLEEP,
    TWCR_SBC_RESTART,
    TWCR_SBC_FAILSAFE
  } twcr_sbc_t;

endpackage : twcr_pkg

// file: logic/twcr_spi_frame.sv
// serial port frame receiver: synchronises the pins and assembles 16-bit frames
`timescale 1ns/1ps
module twcr_spi_frame
  import twcr_pkg::*;
(
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_sclk,
  input  wire logic                      i_chip_select_low,
  input  wire logic                      i_sdi,
  input  wire logic [TWCR_DATA_BITS-1:0] i_rdata,
  output logic      [TWCR_ADDR_BITS-1:0] o_rd_addr,
  output logic                           o_sdo,
  output logic                           o_sdo_en,
  output logic                           o_frame_done,
  output logic                           o_frame_error,
  output logic                           o_frame_write,
  output logic      [TWCR_ADDR_BITS-1:0] o_frame_addr,
  output logic      [TWCR_DATA_BITS-1:0] o_frame_data
);

  // -------------------------------------------------------------------------
  // pin synchronisers: bit 0 sclk, bit 1 chip select, bit 2 data in
  // -------------------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;

  assign pin_raw = {i_sdi, i_chip_select_low, i_sclk};

  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
        sync1_q[g] <= (g == 1);
        sync2_q[g] <= (g == 1);
        prev_q[g]  <= (g == 1);
      end else begin
        sync1_q[g] <= pin_raw[g];
        sync2_q[g] <= sync1_q[g];
        prev_q[g]  <= sync2_q[g];
      end
    end
  end

  wire sclk_rise = sync2_q[0] & ~prev_q[0];
  wire sclk_fall = ~sync2_q[0] & prev_q[0];
  wire cs_fall   = ~sync2_q[1] & prev_q[1];
  wire cs_rise   = sync2_q[1] & ~prev_q[1];
  wire cs_active = ~sync2_q[1];

  // -------------------------------------------------------------------------
  // shift registers
  // -------------------------------------------------------------------------
  logic [4:0]                cnt_q;
  logic [TWCR_FRAME_BITS-1:0] shift_q;
  logic [TWCR_DATA_BITS-1:0]  out_q;

  // address is complete once eight bits are in: write flag then seven bits
  assign o_rd_addr = shift_q[TWCR_ADDR_BITS-1:0];
  assign o_sdo     = out_q[TWCR_DATA_BITS-1];

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q   <= '0;
      shift_q <= '0;
      out_q   <= '0;
    end else if (cs_fall) begin
      cnt_q <= '0;
      out_q <= '0;
    end else if (cs_active && sclk_rise) begin
      shift_q <= {shift_q[TWCR_FRAME_BITS-2:0], sync2_q[2]};
      cnt_q   <= (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
    end else if (cs_active && sclk_fall) begin
      // the addressed register leaves during the second byte
      out_q <= (cnt_q == TWCR_CNT_ADDR) ? i_rdata : {out_q[TWCR_DATA_BITS-2:0], 1'b0};
    end
  end

  // frame is acted on only when chip select returns high after exactly 16 bits
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sdo_en      <= 1'b0;
      o_frame_done  <= 1'b0;
      o_frame_error <= 1'b0;
      o_frame_write <= 1'b0;
      o_frame_addr  <= '0;
      o_frame_data  <= '0;
    end else begin
      o_sdo_en      <= cs_active;
      o_frame_done  <= cs_rise && (cnt_q == TWCR_CNT_FRAME);
      o_frame_error <= cs_rise && (cnt_q != TWCR_CNT_FRAME);
      o_frame_write <= shift_q[TWCR_FRAME_BITS-1];
      o_frame_addr  <= shift_q[TWCR_FRAME_BITS-2:TWCR_DATA_BITS];
      o_frame_data  <= shift_q[TWCR_DATA_BITS-1:0];
    end
  end

endmodule : twcr_spi_frame

// file: logic/twcr_regs.sv
// transceiver mode and wake configuration register bank behind the serial port
`timescale 1ns/1ps
// Functional notes
// - flash bit set turns LIN slope control off for rates up to 115kBaud.
// - low-slope bit selects 10.4kBaud LIN low-slope operation.
// - time-out bit enables LIN transmit-input time-out protection.
// - first LIN mode field 4:3 codes off, wake, receive-only, normal; hardware-updatable.
// - CAN mode field 1:0 codes off, wake, receive-only, normal; hardware-updatable.
// - reserved bits always read zero whatever was written.
// - LIN option bits take effect at chip-select rise, for both LIN transceivers.
// - fail-safe entry forces wake-capable values into three registers.
// - second LIN mode field 1:0 codes off, wake, receive-only, normal; hardware-updatable.
// - peak threshold bit set selects the higher regulator peak current threshold.
// - peak threshold bit is writable only in init or normal mode.
// - in stop mode peak writes are dropped silently, no failure, no alert.
// - bit 7 of internal wake register enables second timer wake.
// - bit 6 of internal wake register enables first timer wake.
// - bit 2 disables watchdog in stop mode; hardware-updatable.
// - alert line covers wake events only, or all status when global set.
// - measurement bit masks wake inputs one and two enables.
// - in normal mode with measurement, levels of inputs one and two invalid.
// - bits 2..0 enable wake inputs three, two and one.
// - primary resets to 0x20; restart keeps 7:5, clears bit 2, loads modes.
// - secondary restart keeps peak bit, clears reserved, loads second LIN mode.
module twcr_regs
  import twcr_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_sclk,
  input  wire logic       i_chip_select_low,
  input  wire logic       i_sdi,
  output logic            o_sdo,
  output logic            o_sdo_en,
  input  wire twcr_sbc_t  i_sbc_state,
  input  wire logic       i_soft_reset,
  input  wire logic       i_restart,
  input  wire logic       i_failsafe_entry,
  input  wire logic [1:0] i_restart_can_mode,
  input  wire logic [1:0] i_restart_first_lin_mode,
  input  wire logic [1:0] i_restart_second_lin_mode,
  input  wire logic       i_hw_can_mode_we,
  input  wire logic [1:0] i_hw_can_mode,
  input  wire logic       i_hw_first_lin_we,
  input  wire logic [1:0] i_hw_first_lin_mode,
  input  wire logic       i_hw_second_lin_we,
  input  wire logic [1:0] i_hw_second_lin_mode,
  input  wire logic       i_hw_wd_stop_we,
  input  wire logic       i_hw_wd_stop_val,
  input  wire logic       i_wake_event,
  input  wire logic       i_status_event,
  output logic            o_lin_slope_off,
  output logic            o_low_slope_select,
  output logic            o_transmit_timeout_enable,
  output logic [1:0]      o_can_mode,
  output logic [1:0]      o_first_lin_mode,
  output logic [1:0]      o_second_lin_mode,
  output logic            o_peak_current_threshold_select,
  output logic            o_second_timer_wake_enable,
  output logic            o_first_timer_wake_enable,
  output logic            o_watchdog_stop_disable_hi,
  output logic            o_int_global,
  output logic            o_measurement_active,
  output logic [2:0]      o_wake_enable,
  output logic [1:0]      o_wake_level_valid,
  output logic            o_alert,
  output logic            o_spi_fail
);

  // -------------------------------------------------------------------------
  // serial front end
  // -------------------------------------------------------------------------
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic       frame_done;
  logic       frame_error;
  logic       frame_write;
  logic [6:0] frame_addr;
  logic [7:0] frame_data;

  twcr_spi_frame u_frame (
    .i_ref_clk         (i_ref_clk),
    .i_rst             (i_rst),
    .i_sclk            (i_sclk),
    .i_chip_select_low (i_chip_select_low),
    .i_sdi             (i_sdi),
    .i_rdata           (rd_data),
    .o_rd_addr         (rd_addr),
    .o_sdo             (o_sdo),
    .o_sdo_en          (o_sdo_en),
    .o_frame_done      (frame_done),
    .o_frame_error     (frame_error),
    .o_frame_write     (frame_write),
    .o_frame_addr      (frame_addr),
    .o_frame_data      (frame_data)
  );

  // -------------------------------------------------------------------------
  // register storage
  // -------------------------------------------------------------------------
  logic [7:0] pri_q;
  logic [7:0] pri_d;
  logic [7:0] sec_q;
  logic [7:0] sec_d;
  logic [7:0] iwk_q;
  logic [7:0] iwk_d;
  logic [7:0] ewk_q;
  logic [7:0] ewk_d;

  // writes land on the chip-select rise, so LIN options switch together then
  wire wr_any = frame_done & frame_write;
  wire wr_pri = wr_any & (frame_addr == TWCR_ADDR_PRIMARY);
  wire wr_sec = wr_any & (frame_addr == TWCR_ADDR_SECONDARY);
  wire wr_iwk = wr_any & (frame_addr == TWCR_ADDR_INT_WAKE);
  wire wr_ewk = wr_any & (frame_addr == TWCR_ADDR_EXT_WAKE);

  // stop mode turns the peak bit read-only without flagging the frame
  wire peak_writable = (i_sbc_state == TWCR_SBC_INIT) ||
                       (i_sbc_state == TWCR_SBC_NORMAL);
  wire peak_new = peak_writable ? frame_data[TWCR_SEC_PEAK_BIT]
                                : sec_q[TWCR_SEC_PEAK_BIT];

  // read mux; stored reserved bits are always zero, unmapped reads give zero
  assign rd_data = (rd_addr == TWCR_ADDR_PRIMARY)   ? pri_q :
                   (rd_addr == TWCR_ADDR_SECONDARY) ? sec_q :
                   (rd_addr == TWCR_ADDR_INT_WAKE)  ? iwk_q :
                   (rd_addr == TWCR_ADDR_EXT_WAKE)  ? ewk_q : 8'h00;

  // priority: soft reset, fail-safe, restart, then host write overlaid by hardware
  always_comb begin
    pri_d = pri_q;
    if (i_soft_reset) begin
      pri_d = TWCR_PRIMARY_RST;
    end else if (i_failsafe_entry) begin
      pri_d = {pri_q[7:5], TWCR_TRX_WAKE, 1'b0, TWCR_TRX_WAKE};
    end else if (i_restart) begin
      pri_d = {pri_q[7:5], i_restart_first_lin_mode, 1'b0, i_restart_can_mode};
    end else begin
      if (wr_pri) begin
        pri_d = frame_data & TWCR_PRIMARY_MASK;
      end
      if (i_hw_can_mode_we) begin
        pri_d[TWCR_PRI_CAN_LSB +: 2] = i_hw_can_mode;
      end
      if (i_hw_first_lin_we) begin
        pri_d[TWCR_PRI_FIRST_LIN_MODE_LSB +: 2] = i_hw_first_lin_mode;
      end
    end
  end

  always_comb begin
    sec_d = sec_q;
    if (i_soft_reset) begin
      sec_d = TWCR_SECONDARY_RST;
    end else if (i_failsafe_entry) begin
      sec_d = {6'h00, TWCR_TRX_WAKE};
    end else if (i_restart) begin
      sec_d = {2'h0, sec_q[TWCR_SEC_PEAK_BIT], 3'h0, i_restart_second_lin_mode};
    end else begin
      if (wr_sec) begin
        sec_d = {2'h0, peak_new, 3'h0, frame_data[TWCR_SEC_SECOND_LIN_MODE_LSB +: 2]};
      end
      if (i_hw_second_lin_we) begin
        sec_d[TWCR_SEC_SECOND_LIN_MODE_LSB +: 2] = i_hw_second_lin_mode;
      end
    end
  end

  always_comb begin
    iwk_d = iwk_q;
    if (i_soft_reset) begin
      iwk_d = TWCR_INT_WAKE_RST;
    end else if (i_restart) begin
      iwk_d = {iwk_q[7:6], 6'h00};
    end else begin
      if (wr_iwk) begin
        iwk_d = frame_data & TWCR_INT_WAKE_MASK;
      end
      if (i_hw_wd_stop_we) begin
        iwk_d[TWCR_INT_WDSTOP_BIT] = i_hw_wd_stop_val;
      end
    end
  end

  always_comb begin
    ewk_d = ewk_q;
    if (i_soft_reset) begin
      ewk_d = TWCR_EXT_WAKE_RST;
    end else if (i_failsafe_entry) begin
      ewk_d = {ewk_q[7], 1'b0, ewk_q[5], 2'h0, TWCR_FAIL_WAKE_EN};
    end else if (wr_ewk) begin
      ewk_d = frame_data & TWCR_EXT_WAKE_MASK;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pri_q <= TWCR_PRIMARY_RST;
      sec_q <= TWCR_SECONDARY_RST;
      iwk_q <= TWCR_INT_WAKE_RST;
      ewk_q <= TWCR_EXT_WAKE_RST;
    end else begin
      pri_q <= pri_d;
      sec_q <= sec_d;
      iwk_q <= iwk_d;
      ewk_q <= ewk_d;
    end
  end

  // -------------------------------------------------------------------------
  // field outputs, straight from the register flops
  // -------------------------------------------------------------------------
  assign o_lin_slope_off                 = pri_q[TWCR_PRI_FLASH_BIT];
  assign o_low_slope_select              = pri_q[TWCR_PRI_LOWSLP_BIT];
  assign o_transmit_timeout_enable       = pri_q[TWCR_PRI_TXDTO_BIT];
  assign o_first_lin_mode                = pri_q[TWCR_PRI_FIRST_LIN_MODE_LSB +: 2];
  assign o_can_mode                      = pri_q[TWCR_PRI_CAN_LSB +: 2];
  assign o_second_lin_mode               = sec_q[TWCR_SEC_SECOND_LIN_MODE_LSB +: 2];
  assign o_peak_current_threshold_select = sec_q[TWCR_SEC_PEAK_BIT];
  assign o_second_timer_wake_enable      = iwk_q[TWCR_INT_TMR2_BIT];
  assign o_first_timer_wake_enable       = iwk_q[TWCR_INT_TMR1_BIT];
  assign o_watchdog_stop_disable_hi      = iwk_q[TWCR_INT_WDSTOP_BIT];
  assign o_int_global                    = ewk_q[TWCR_EXT_GLOBAL_BIT];

  // -------------------------------------------------------------------------
  // derived wake, measurement and alert outputs
  // -------------------------------------------------------------------------
  wire       meas_sel     = ewk_q[TWCR_EXT_MEAS_BIT];
  wire [2:0] wake_en_d    = {ewk_q[2], meas_sel ? 2'b00 : ewk_q[1:0]};
  wire       meas_act_d   = meas_sel & (i_sbc_state == TWCR_SBC_NORMAL);
  // a stop-mode peak write raises nothing; only short or long frames count as failures
  wire       alert_d      = i_wake_event |
                            (ewk_q[TWCR_EXT_GLOBAL_BIT] & (i_status_event | frame_error));

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wake_enable        <= TWCR_EXT_WAKE_RST[2:0];
      o_measurement_active <= 1'b0;
      o_wake_level_valid   <= 2'b11;
      o_alert              <= 1'b0;
      o_spi_fail           <= 1'b0;
    end else begin
      o_wake_enable        <= wake_en_d;
      o_measurement_active <= meas_act_d;
      o_wake_level_valid   <= {2{~meas_act_d}};
      o_alert              <= alert_d;
      o_spi_fail           <= frame_error;
    end
  end

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  wire quiet = !i_soft_reset && !i_failsafe_entry && !i_restart;

  sequence s_host_write_pri;
    wr_pri && quiet && !i_hw_can_mode_we && !i_hw_first_lin_we;
  endsequence

  sequence s_stop_write_sec;
    wr_sec && quiet && (i_sbc_state == TWCR_SBC_STOP);
  endsequence

  sequence s_restart_only;
    i_restart && !i_soft_reset && !i_failsafe_entry;
  endsequence

  sequence s_hw_update;
    quiet && i_hw_can_mode_we && i_hw_second_lin_we;
  endsequence

  sequence s_unmapped_write;
    wr_any && quiet && !(wr_pri || wr_sec || wr_iwk || wr_ewk) && !i_hw_can_mode_we &&
    !i_hw_first_lin_we && !i_hw_second_lin_we && !i_hw_wd_stop_we;
  endsequence

  a_lin_options_land: assert property (s_host_write_pri |=>
    (pri_q[7:5] == $past(frame_data[7:5])) && (o_lin_slope_off == $past(frame_data[7])))
    else $error("LIN option bits did not follow the primary write");

  a_reserved_zero: assert property (
    ((pri_q & ~TWCR_PRIMARY_MASK) == 8'h00) && ((sec_q & ~TWCR_SECONDARY_MASK) == 8'h00) &&
    ((iwk_q & ~TWCR_INT_WAKE_MASK) == 8'h00) && ((ewk_q & ~TWCR_EXT_WAKE_MASK) == 8'h00))
    else $error("reserved register bit is not zero");

  a_failsafe_force: assert property ((i_failsafe_entry && !i_soft_reset) |=>
    (pri_q[4:0] == 5'h09) && (sec_q == 8'h01) && (ewk_q[6] == 1'b0) && (ewk_q[4:0] == 5'h07)
    && (pri_q[7:5] == $past(pri_q[7:5])))
    else $error("fail-safe values not forced");

  a_peak_stop_dropped: assert property (s_stop_write_sec |=>
    ($stable(o_peak_current_threshold_select) && !o_spi_fail && !o_alert) ##1
    (!o_spi_fail && !o_alert))
    else $error("peak bit changed or failure raised in stop mode");

  a_peak_write_taken: assert property ((wr_sec && quiet && peak_writable) |=>
    o_peak_current_threshold_select == $past(frame_data[5]))
    else $error("peak bit not written in init or normal mode");

  a_restart_primary: assert property (s_restart_only |=>
    (pri_q[7:5] == $past(pri_q[7:5])) && !pri_q[2] &&
    (o_can_mode == $past(i_restart_can_mode)) &&
    (o_first_lin_mode == $past(i_restart_first_lin_mode)))
    else $error("restart value of primary register wrong");

  a_restart_secondary: assert property (s_restart_only |=>
    (sec_q == {2'h0, $past(sec_q[5]), 3'h0, $past(i_restart_second_lin_mode)}))
    else $error("restart value of secondary register wrong");

  a_hw_mode_update: assert property (s_hw_update |=>
    (o_can_mode == $past(i_hw_can_mode)) && (o_second_lin_mode == $past(i_hw_second_lin_mode)))
    else $error("hardware mode update not reflected");

  a_alert_wake: assert property ((i_wake_event || !o_int_global) |=>
    (o_alert == $past(i_wake_event)))
    else $error("alert does not follow wake events");

  a_meas_masking: assert property (meas_sel |=> (o_wake_enable[1:0] == 2'b00) &&
    (o_wake_enable[2] == $past(ewk_q[2])))
    else $error("wake inputs one and two not masked by measurement");

  a_level_invalid: assert property (meas_act_d |=> (o_wake_level_valid == 2'b00)
    && o_measurement_active)
    else $error("level status still valid during measurement");

  a_soft_reset_vals: assert property (i_soft_reset |=> ((pri_q == TWCR_PRIMARY_RST) &&
    (sec_q == TWCR_SECONDARY_RST) && (iwk_q == TWCR_INT_WAKE_RST) &&
    (ewk_q == TWCR_EXT_WAKE_RST)) ##1 (o_wake_enable == 3'h7))
    else $error("soft reset values wrong");

  a_alert_global: assert property ((o_int_global && (i_status_event || frame_error)) |=>
    o_alert)
    else $error("alert not raised for a status event with global alerts on");

  a_frame_fail: assert property ((frame_done || frame_error) |=>
    (o_spi_fail == $past(frame_error)))
    else $error("failure flag does not match the frame length");

  a_wake_enable_plain: assert property (!meas_sel |=>
    (o_wake_enable == $past(ewk_q[2:0])))
    else $error("wake enables do not follow the external wake register");

  a_unmapped_write: assert property (s_unmapped_write |=>
    $stable(pri_q) && $stable(sec_q) && $stable(iwk_q) && $stable(ewk_q))
    else $error("write outside the register range changed a register");

endmodule : twcr_regs

// file: tb/twcr_host_model.sv
// host model: serial port master sending 16-bit frames msb first
`timescale 1ns/1ps
module twcr_host_model (
  input  wire logic i_ref_clk,
  input  wire logic i_sdo,
  output logic      o_sclk = 1'b0,
  output logic      o_chip_select_low = 1'b1,
  output logic      o_sdi = 1'b0
);
  // each sclk phase lasts 4 reference cycles, an 80 ns period
  task automatic xfer(input logic [15:0] frm, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    repeat (4) @(negedge i_ref_clk);
    o_chip_select_low = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_sdi = frm[15-i];
      repeat (4) @(negedge i_ref_clk);
      o_sclk = 1'b1;
      rd = {rd[6:0], i_sdo};
      repeat (4) @(negedge i_ref_clk);
      o_sclk = 1'b0;
    end
    repeat (4) @(negedge i_ref_clk);
    o_chip_select_low = 1'b1;
    // released line shows the inverse so a stale bit never passes for data
    o_sdi = ~o_sdi;
    repeat (8) @(negedge i_ref_clk);
  endtask : xfer
endmodule : twcr_host_model

// file: tb/twcr_regs_tb.sv
// self-checking bench for the transceiver and wake configuration registers
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module twcr_regs_tb;
  import twcr_pkg::*;
  logic       clk = 0, rst = 1, sclk, csl, sdi, sdo, sdo_en, sre = 0, rsr = 0, fse = 0;
  logic       hwe = 0, wev = 0, sev = 0, wdv = 1, slp, lsm, tto, pk, t2, t1, wd, glb;
  logic       meas, alert, sfail, a_seen = 0, f_seen = 0, e_seen = 0;
  logic [1:0] md = 2'h2, can_m, first_lin_mode, second_lin_mode, lvl;
  logic [2:0] wen;
  logic [7:0] rd;
  twcr_sbc_t  st = TWCR_SBC_NORMAL;
  int         mismatches = 0, cmp_count = 0;
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    if (alert) a_seen <= 1'b1;
    if (sfail) f_seen <= 1'b1;
    if (sdo_en) e_seen <= 1'b1;
  end
  twcr_host_model i_host (.i_ref_clk(clk), .i_sdo(sdo), .o_sclk(sclk),
    .o_chip_select_low(csl), .o_sdi(sdi));
  twcr_regs i_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_chip_select_low(csl), .i_sdi(sdi),
    .o_sdo(sdo), .o_sdo_en(sdo_en), .i_sbc_state(st), .i_soft_reset(sre), .i_restart(rsr),
    .i_failsafe_entry(fse), .i_restart_can_mode(md), .i_restart_first_lin_mode(md),
    .i_restart_second_lin_mode(md), .i_hw_can_mode_we(hwe), .i_hw_can_mode(md),
    .i_hw_first_lin_we(hwe), .i_hw_first_lin_mode(md), .i_hw_second_lin_we(hwe),
    .i_hw_second_lin_mode(md), .i_hw_wd_stop_we(hwe), .i_hw_wd_stop_val(wdv),
    .i_wake_event(wev), .i_status_event(sev), .o_lin_slope_off(slp), .o_low_slope_select(lsm),
    .o_transmit_timeout_enable(tto), .o_can_mode(can_m), .o_first_lin_mode(first_lin_mode),
    .o_second_lin_mode(second_lin_mode), .o_peak_current_threshold_select(pk),
    .o_second_timer_wake_enable(t2), .o_first_timer_wake_enable(t1),
    .o_watchdog_stop_disable_hi(wd), .o_int_global(glb), .o_measurement_active(meas),
    .o_wake_enable(wen), .o_wake_level_valid(lvl), .o_alert(alert), .o_spi_fail(sfail));
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host.xfer({1'b1, a, d}, 16, rd);
  endtask : wr
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    i_host.xfer({1'b0, a, 8'h00}, 16, rd);
    `CHK(rd, e)
  endtask : rc
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
    repeat (2) @(negedge clk);
  endtask : pulse
  task automatic t_reset();
    wr(7'h08, 8'hff);
    rc(7'h04, 8'h20);
    rc(7'h05, 8'h00);
    rc(7'h06, 8'h00);
    rc(7'h07, 8'h07);
    rc(7'h08, 8'h00);
    `CHK({e_seen, sdo_en}, 2'h2)
  endtask : t_reset
  task automatic t_modes();
    wr(7'h04, 8'hff);
    `CHK({slp, lsm, tto}, 3'h7)
    rc(7'h04, 8'hfb);
    for (int m = 0; m < 4; m++) begin
      wr(7'h04, {3'h0, m[1:0], 1'b1, m[1:0]});
      wr(7'h05, {6'h3f, m[1:0]});
      `CHK({first_lin_mode, can_m, second_lin_mode, slp}, {m[1:0], m[1:0], m[1:0], 1'b0})
    end
    rc(7'h05, 8'h23);
    `CHK(pk, 1'b1)
  endtask : t_modes
  task automatic t_stop_and_wake();
    wr(7'h07, 8'h80);
    st = TWCR_SBC_STOP;
    a_seen <= 1'b0;
    f_seen <= 1'b0;
    wr(7'h05, 8'h02);
    rc(7'h05, 8'h22);
    `CHK({a_seen, f_seen}, 2'h0)
    i_host.xfer(16'h8400, 12, rd);
    `CHK({a_seen, f_seen}, 2'h3)
    st = TWCR_SBC_NORMAL;
    wr(7'h07, 8'h27);
    `CHK({meas, wen, lvl}, 6'h30)
    wr(7'h07, 8'h05);
    `CHK({meas, wen, lvl, glb}, 7'h2e)
    a_seen <= 1'b0;
    pulse(sev);
    `CHK(a_seen, 1'b0)
    pulse(wev);
    `CHK(a_seen, 1'b1)
    wr(7'h06, 8'hff);
    `CHK({t2, t1, wd}, 3'h7)
    rc(7'h06, 8'hc4);
  endtask : t_stop_and_wake
  task automatic t_events();
    wr(7'h04, 8'hf8);
    wr(7'h07, 8'ha0);
    pulse(fse);
    rc(7'h04, 8'he9);
    rc(7'h05, 8'h01);
    rc(7'h07, 8'ha7);
    wr(7'h05, 8'h20);
    pulse(rsr);
    rc(7'h04, 8'hf2);
    rc(7'h05, 8'h22);
    md = 2'h3;
    pulse(hwe);
    rc(7'h04, 8'hfb);
    rc(7'h05, 8'h23);
    rc(7'h06, 8'hc4);
    pulse(sre);
    rc(7'h04, 8'h20);
  endtask : t_events
  task automatic final_report();
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_modes();
    t_stop_and_wake();
    t_events();
    final_report();
  end
  // about 40 frames of 1.5 us each; a generous margin cuts a hang short
  initial begin
    #200us;
    mismatches++;
    final_report();
  end
endmodule : twcr_regs_tb
